// [inc/timer_consts.svh]
// Register offsets, bit positions and timing constants of the timer block
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define ADR_TIMER_CTRL   8'h88
`define ADR_TIMER_MODE   8'h89
`define ADR_FT_LOW       8'h8A
`define ADR_ST_LOW       8'h8B
`define ADR_FT_HIGH      8'h8C
`define ADR_ST_HIGH      8'h8D
`define ADR_CLKDIV       8'h8E
`define ADR_IEN          8'hA8
`define ADR_IPRI         8'hB8
`define ADR_TT_CTRL      8'hC8
`define ADR_TT_RLD_LO    8'hCA
`define ADR_TT_RLD_HI    8'hCB
`define ADR_TT_CNT_LO    8'hCC
`define ADR_TT_CNT_HI    8'hCD
`define ADR_SER_CTRL     8'h87
`define RST_BYTE         8'h00
`define BIT_TF1          7
`define BIT_TR1          6
`define BIT_TF0          5
`define BIT_TR0          4
`define BIT_SECOND_TIMER_GATE_INPUT        7
`define BIT_CT1          6
`define BIT_FIRST_TIMER_GATE_INPUT        3
`define BIT_CT0          2
`define BIT_TF2          7
`define BIT_EXTERNAL_TRIGGER_FLAG         6
`define BIT_RCLK         5
`define BIT_TRANSMIT_BAUD_SELECT         4
`define BIT_EXEN         3
`define BIT_TR2          2
`define BIT_CT2          1
`define BIT_CPRL         0
`define BIT_PRE2         5
`define BIT_PRE1         4
`define BIT_PRE0         3
`define BIT_EA           7
`define BIT_ET2          5
`define BIT_PT2          5
`define BIT_SERIAL_DOUBLE_RATE_BIT         7
`define DIV_FAST         4'd3
`define DIV_SLOW         4'd11
`define LOW5_MAX         5'h1F
`endif

// [inc/timer_pkg.sv]
// Types shared by the timer block
package timer_pkg;
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } tmode_t;
  typedef struct packed {
    logic [7:0] adr;
    logic       we;
    logic [7:0] dat;
  } bus_req_t;
endpackage

// [hw/timer_block.sv]
// Timer one/two/three counters with a classic Wishbone register slave
//
// Chosen here: the Wishbone interface to the registers.
`include "timer_consts.svh"
module timer_block
  import timer_pkg::*;
(
  // System
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [7:0] adr_i,
  input  wire logic       sel_i,
  input  wire logic [7:0] dat_i,
  output logic      [7:0] dat_o,
  output logic            ack_o,
  // Pins
  input  wire logic       t0_pin_i,
  input  wire logic       first_timer_gate_input_i,
  input  wire logic       t1_pin_i,
  input  wire logic       second_timer_gate_input_i,
  input  wire logic       third_timer_external_clock_i,
  input  wire logic       trigger_input_pin_i,
  // To core and UART
  output logic            third_irq_o,
  output logic            third_irq_high_o,
  output logic            tx_baud_tick_o,
  output logic            rx_baud_tick_o
);
  bus_req_t   req;
  logic [7:0] tcon_r, tmod_r, clock_divider_control_r, ie_r, ip_r, third_timer_control_r, pcon_r;
  logic [7:0] tl0_r, th0_r, tl1_r, th1_r, tl2_r, th2_r, rl2_r, rh2_r;
  logic [3:0] pre0_r, pre1_r, pre2_r;
  logic       t0_d_r, t1_d_r, t2_d_r, ex_d_r, half_r;
  logic       wr, tick0, tick1, tick2, fall2, fallx, t2ovf, baud;
  logic       inc0, inc0h, inc1, inc2, ovf0, ovf0h, ovf1;
  tmode_t     m0, m1;

  assign req   = '{adr: adr_i, we: we_i, dat: dat_i};
  assign wr    = cyc_i && stb_i && req.we && sel_i && !ack_o;
  assign m0    = tmode_t'(tmod_r[1:0]);
  assign m1    = tmode_t'(tmod_r[5:4]);
  assign baud  = third_timer_control_r[`BIT_RCLK] | third_timer_control_r[`BIT_TRANSMIT_BAUD_SELECT];

  // Bus answer one cycle after the request, then dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `RST_BYTE;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      case (req.adr)
        `ADR_TIMER_CTRL: dat_o <= tcon_r;
        `ADR_TIMER_MODE: dat_o <= tmod_r;
        `ADR_FT_LOW:     dat_o <= tl0_r;
        `ADR_ST_LOW:     dat_o <= tl1_r;
        `ADR_FT_HIGH:    dat_o <= th0_r;
        `ADR_ST_HIGH:    dat_o <= th1_r;
        `ADR_CLKDIV:     dat_o <= clock_divider_control_r;
        `ADR_IEN:        dat_o <= ie_r;
        `ADR_IPRI:       dat_o <= ip_r;
        `ADR_TT_CTRL:    dat_o <= third_timer_control_r;
        `ADR_TT_RLD_LO:  dat_o <= rl2_r;
        `ADR_TT_RLD_HI:  dat_o <= rh2_r;
        `ADR_TT_CNT_LO:  dat_o <= tl2_r;
        `ADR_TT_CNT_HI:  dat_o <= th2_r;
        `ADR_SER_CTRL:   dat_o <= pcon_r;
        default:         dat_o <= `RST_BYTE;
      endcase
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmod_r  <= `RST_BYTE;
      clock_divider_control_r <= `RST_BYTE;
      ie_r    <= `RST_BYTE;
      ip_r    <= `RST_BYTE;
      pcon_r  <= `RST_BYTE;
    end else if (wr) begin
      if (req.adr == `ADR_TIMER_MODE) tmod_r  <= req.dat;
      if (req.adr == `ADR_CLKDIV)     clock_divider_control_r <= req.dat;
      if (req.adr == `ADR_IEN)        ie_r    <= req.dat;
      if (req.adr == `ADR_IPRI)       ip_r    <= req.dat;
      if (req.adr == `ADR_SER_CTRL)   pcon_r  <= req.dat;
    end
  end

  // Input edge samplers, pins are already synchronous
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t0_d_r <= 1'b0;
      t1_d_r <= 1'b0;
      t2_d_r <= 1'b0;
      ex_d_r <= 1'b0;
    end else begin
      t0_d_r <= t0_pin_i;
      t1_d_r <= t1_pin_i;
      t2_d_r <= third_timer_external_clock_i;
      ex_d_r <= trigger_input_pin_i;
    end
  end
  assign fall2 = t2_d_r && !third_timer_external_clock_i;
  assign fallx = ex_d_r && !trigger_input_pin_i &&
                 third_timer_control_r[`BIT_EXEN];

  // Prescalers: divide by 4 or 12 per prescale bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre0_r <= 4'h0;
      pre1_r <= 4'h0;
      pre2_r <= 4'h0;
    end else begin
      pre0_r <= tick0 ? 4'h0 : pre0_r + 4'h1;
      pre1_r <= tick1 ? 4'h0 : pre1_r + 4'h1;
      pre2_r <= tick2 ? 4'h0 : pre2_r + 4'h1;
    end
  end
  assign tick0 = pre0_r >= (clock_divider_control_r[`BIT_PRE0] ? `DIV_FAST : `DIV_SLOW);
  assign tick1 = pre1_r >= (clock_divider_control_r[`BIT_PRE1] ? `DIV_FAST : `DIV_SLOW);
  assign tick2 = pre2_r >= (clock_divider_control_r[`BIT_PRE2] ? `DIV_FAST : `DIV_SLOW);

  // First timer low byte in split mode, high byte on internal clock
  assign inc0  = tcon_r[`BIT_TR0] &&
                 (!tmod_r[`BIT_FIRST_TIMER_GATE_INPUT] || first_timer_gate_input_i) &&
                 (tmod_r[`BIT_CT0] ? (t0_d_r && !t0_pin_i) : tick0);
  assign ovf0  = inc0 && tl0_r == 8'hFF;
  assign inc0h = tcon_r[`BIT_TR1] && tick0;
  assign ovf0h = inc0h && th0_r == 8'hFF;

  // Second timer enable: run and gate; mode 3 holds
  assign inc1 = tcon_r[`BIT_TR1] && m1 != MODE_SPLIT &&
                (!tmod_r[`BIT_SECOND_TIMER_GATE_INPUT] || second_timer_gate_input_i) &&
                (tmod_r[`BIT_CT1] ? (t1_d_r && !t1_pin_i) : tick1);
  always_comb begin
    case (m1)
      MODE_13BIT:  ovf1 = inc1 && th1_r == 8'hFF &&
                          tl1_r[4:0] == `LOW5_MAX;
      MODE_16BIT:  ovf1 = inc1 && {th1_r, tl1_r} == 16'hFFFF;
      MODE_RELOAD: ovf1 = inc1 && tl1_r == 8'hFF;
      default:     ovf1 = 1'b0;
    endcase
  end

  // Counters of the first two timers; software writes take priority
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tl0_r <= `RST_BYTE;
      th0_r <= `RST_BYTE;
      tl1_r <= `RST_BYTE;
      th1_r <= `RST_BYTE;
    end else begin
      if (wr && req.adr == `ADR_FT_LOW)
        tl0_r <= req.dat;
      else if (m0 == MODE_SPLIT && inc0)
        tl0_r <= tl0_r + 8'h01;
      if (wr && req.adr == `ADR_FT_HIGH)
        th0_r <= req.dat;
      else if (m0 == MODE_SPLIT && inc0h)
        th0_r <= th0_r + 8'h01;
      if (wr && req.adr == `ADR_ST_LOW) begin
        tl1_r <= req.dat;
      end else if (inc1) begin
        case (m1)
          MODE_13BIT:  tl1_r <= {tl1_r[7:5], tl1_r[4:0] + 5'h01};
          MODE_16BIT:  tl1_r <= tl1_r + 8'h01;
          MODE_RELOAD: tl1_r <= ovf1 ? th1_r : tl1_r + 8'h01;
          default:     tl1_r <= tl1_r;
        endcase
      end
      if (wr && req.adr == `ADR_ST_HIGH)
        th1_r <= req.dat;
      else if (inc1 && ((m1 == MODE_13BIT && tl1_r[4:0] == `LOW5_MAX) ||
                        (m1 == MODE_16BIT && tl1_r == 8'hFF)))
        th1_r <= th1_r + 8'h01;
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcon_r <= `RST_BYTE;
    end else begin
      if (wr && req.adr == `ADR_TIMER_CTRL)
        tcon_r <= req.dat;
      if (m0 == MODE_SPLIT ? ovf0h : ovf1)
        tcon_r[`BIT_TF1] <= 1'b1;
      if (m0 == MODE_SPLIT && ovf0)
        tcon_r[`BIT_TF0] <= 1'b1;
    end
  end

  // Third timer
  assign inc2  = third_timer_control_r[`BIT_TR2] &&
                 (third_timer_control_r[`BIT_CT2] ? fall2 :
                  (baud ? 1'b1 : tick2));
  assign t2ovf = inc2 && {th2_r, tl2_r} == 16'hFFFF;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tl2_r <= `RST_BYTE;
      th2_r <= `RST_BYTE;
      rl2_r <= `RST_BYTE;
      rh2_r <= `RST_BYTE;
    end else begin
      if (t2ovf && (baud || !third_timer_control_r[`BIT_CPRL])) begin
        {th2_r, tl2_r} <= {rh2_r, rl2_r};
      end else if (fallx && !baud && !third_timer_control_r[`BIT_CPRL]) begin
        {th2_r, tl2_r} <= {rh2_r, rl2_r};
      end else if (inc2) begin
        {th2_r, tl2_r} <= {th2_r, tl2_r} + 16'h0001;
      end
      if (wr && req.adr == `ADR_TT_CNT_LO) tl2_r <= req.dat;
      if (wr && req.adr == `ADR_TT_CNT_HI) th2_r <= req.dat;
      if (fallx && !baud && third_timer_control_r[`BIT_CPRL])
        {rh2_r, rl2_r} <= {th2_r, tl2_r};
      if (wr && req.adr == `ADR_TT_RLD_LO) rl2_r <= req.dat;
      if (wr && req.adr == `ADR_TT_RLD_HI) rh2_r <= req.dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      third_timer_control_r <= `RST_BYTE;
    end else begin
      if (wr && req.adr == `ADR_TT_CTRL)
        third_timer_control_r <= req.dat;
      if (t2ovf && !baud)
        third_timer_control_r[`BIT_TF2] <= 1'b1;
      if (fallx)
        third_timer_control_r[`BIT_EXTERNAL_TRIGGER_FLAG] <= 1'b1;
    end
  end

  // Baud ticks: every second overflow, double-rate bit not consulted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_r         <= 1'b0;
      tx_baud_tick_o <= 1'b0;
      rx_baud_tick_o <= 1'b0;
    end else begin
      if (t2ovf && baud)
        half_r <= !half_r;
      tx_baud_tick_o <= t2ovf && half_r && third_timer_control_r[`BIT_TRANSMIT_BAUD_SELECT];
      rx_baud_tick_o <= t2ovf && half_r && third_timer_control_r[`BIT_RCLK];
    end
  end

  // Interrupt request to the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      third_irq_o      <= 1'b0;
      third_irq_high_o <= 1'b0;
    end else begin
      third_irq_o <= ie_r[`BIT_EA] && ie_r[`BIT_ET2] &&
                     (third_timer_control_r[`BIT_TF2] || third_timer_control_r[`BIT_EXTERNAL_TRIGGER_FLAG]);
      third_irq_high_o <= ip_r[`BIT_PT2];
    end
  end

  // Checks
  a_tf2_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(third_timer_control_r[`BIT_TF2]) |-> $past(wr) &&
      $past(req.adr) == `ADR_TT_CTRL)
    else $error("overflow flag cleared by hardware");
  a_no_tf2_baud: assert property (@(posedge clk_i) disable iff (rst_i)
    t2ovf && baud && !third_timer_control_r[`BIT_TF2] && !wr |=> !third_timer_control_r[`BIT_TF2])
    else $error("overflow flag set in baud use");
  a_t2_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    !third_timer_control_r[`BIT_TR2] && !wr && !fallx |=> $stable({th2_r, tl2_r}))
    else $error("third count ran while stopped");
  a_reload_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
    t2ovf && baud && !wr |=> {th2_r, tl2_r} == $past({rh2_r, rl2_r}))
    else $error("no reload");
  a_exf_set: assert property (@(posedge clk_i) disable iff (rst_i)
    fallx |=> third_timer_control_r[`BIT_EXTERNAL_TRIGGER_FLAG]) else $error("trigger flag lost");
  a_t1_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    m1 == MODE_SPLIT && !wr |=> $stable(th1_r) && $stable(tl1_r))
    else $error("second count moved while halted");
  a_m2_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf1 && m1 == MODE_RELOAD && m0 != MODE_SPLIT && !wr |=>
      tl1_r == $past(th1_r) &&
      tcon_r[`BIT_TF1]) else $error("mode 2 reload");
  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !ie_r[`BIT_EA] |=> !third_irq_o) else $error("irq ungated");
  a_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    fallx && !baud && third_timer_control_r[`BIT_CPRL] && !wr |=>
      {rh2_r, rl2_r} == $past({th2_r, tl2_r}))
    else $error("capture missed");
  c_baud: cover property (@(posedge clk_i) tx_baud_tick_o);
  c_capture: cover property (@(posedge clk_i)
    fallx && third_timer_control_r[`BIT_CPRL]);
  c_split: cover property (@(posedge clk_i) m0 == MODE_SPLIT && ovf0h);
endmodule

// [bench/wb_core_model.sv]
// Processor core model: classic Wishbone master for the timer registers
module wb_core_model (
  // Clock
  input  wire logic       clk_i,
  // Wishbone master
  input  wire logic       ack_i,
  output logic            cyc_o,
  output logic            stb_o,
  output logic            we_o,
  output logic [7:0]      adr_o,
  output logic            sel_o,
  output logic [7:0]      dat_o,
  // Status
  output logic            hung_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 1'b0;
    dat_o = 8'h00;
    hung_o = 1'b0;
  end
  // Request held until the edge that samples ack; read data taken there
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 1'b1;
    dat_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    if (n >= 20) hung_o <= 1'b1;
  endtask
endmodule

// [bench/timer_block_tb_top.sv]
// Self-checking bench for the timer block
`include "timer_consts.svh"
module timer_block_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [7:0] tmod, th, tl, tcon, thx;
  } mrow_t;
  logic       clk_i, rst_i, cyc, stb, we, sel, ack, hung;
  logic [7:0] adr, wdat, rdat;
  logic       t2ck, trg, second_timer_gate_input, irq, irqh, txt, rxt;
  logic [7:0] exp_q[$];
  logic [15:0] v;
  int         failures = 0;
  int         checks = 0;
  int         n;
  logic [7:0] rst_adr[5] = '{`ADR_CLKDIV, `ADR_IEN, `ADR_IPRI,
                             `ADR_TT_CTRL, 8'h90};
  // Second timer: mode, loads, flag byte, high byte after stop
  // Last two rows: gated, pin low then pin high
  mrow_t mt[6] = '{'{8'h00, 8'hFF, 8'h1E, 8'hC0, 8'h00},
                   '{8'h10, 8'hFF, 8'hFE, 8'hC0, 8'h00},
                   '{8'h20, 8'hF0, 8'hFE, 8'hC0, 8'hF0},
                   '{8'h30, 8'hFF, 8'hFE, 8'h40, 8'hFF},
                   '{8'h90, 8'hFF, 8'hFE, 8'h40, 8'hFF},
                   '{8'h90, 8'hFF, 8'hFE, 8'hC0, 8'h00}};
  wb_core_model bus (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hung_o(hung));
  // First timer pins idle: its modes other than split lie outside this block
  timer_block dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .t0_pin_i(1'b1),
    .first_timer_gate_input_i(1'b0), .t1_pin_i(1'b1),
    .second_timer_gate_input_i(second_timer_gate_input),
    .third_timer_external_clock_i(t2ck), .trigger_input_pin_i(trg),
    .third_irq_o(irq), .third_irq_high_o(irqh), .tx_baud_tick_o(txt),
    .rx_baud_tick_o(rxt));
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e) begin
      failures++;
      $display("wrong value at %0t: read %h not %h", $time, got, e);
    end
  endtask
  task automatic cmp_sig(input logic [15:0] got, input logic [15:0] e);
    checks++;
    if (got !== e) begin
      failures++;
      $display("wrong value at %0t: saw %h not %h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus.xfer(1'b0, a, 8'h00);
  endtask
  // Falling edge on the trigger (k=0) or external clock (k=1)
  task automatic fall(input int k);
    if (k == 0) trg <= 1'b0;
    else t2ck <= 1'b0;
    repeat (3) @(posedge clk_i);
    trg <= 1'b1;
    t2ck <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      cmp_rd(rdat, exp_q.pop_front());
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // A hung bus or a stuck run ends here as a failure
  initial begin
    for (int i = 0; i < 30000 && !hung; i++) @(posedge clk_i);
    failures++;
    end_of_test();
  end
  initial begin
    rst_i = 1'b1;
    t2ck = 1'b1;
    trg = 1'b1;
    second_timer_gate_input = 1'b0;
    void'($urandom(53));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rst_adr[i]) rd(rst_adr[i], 8'h00);
    wr(`ADR_CLKDIV, 8'h30);
    foreach (mt[i]) begin
      second_timer_gate_input <= (i == 5);
      wr(`ADR_TIMER_MODE, mt[i].tmod);
      wr(`ADR_ST_HIGH, mt[i].th);
      wr(`ADR_ST_LOW, mt[i].tl);
      wr(`ADR_TIMER_CTRL, 8'h40);
      repeat (30) @(posedge clk_i);
      rd(`ADR_TIMER_CTRL, mt[i].tcon);
      wr(`ADR_TIMER_CTRL, 8'h00);
      rd(`ADR_ST_HIGH, mt[i].thx);
    end
    // Split mode: both byte counters overflow within two prescaled ticks
    wr(`ADR_TIMER_MODE, 8'h03);
    wr(`ADR_FT_LOW, 8'hFE);
    wr(`ADR_FT_HIGH, 8'hFE);
    wr(`ADR_TIMER_CTRL, 8'h50);
    repeat (30) @(posedge clk_i);
    rd(`ADR_TIMER_CTRL, 8'hF0);
    wr(`ADR_TIMER_CTRL, 8'h00);
    wr(`ADR_TIMER_MODE, 8'h00);
    wr(`ADR_TT_RLD_LO, 8'hF0);
    wr(`ADR_TT_RLD_HI, 8'hFF);
    wr(`ADR_TT_CNT_LO, 8'hFE);
    wr(`ADR_TT_CNT_HI, 8'hFF);
    wr(`ADR_TT_CTRL, 8'h04);
    repeat (40) @(posedge clk_i);
    rd(`ADR_TT_CTRL, 8'h84);
    rd(`ADR_TT_CNT_HI, 8'hFF);
    wr(`ADR_TT_CTRL, 8'h80);
    wr(`ADR_IEN, 8'hA0);
    wr(`ADR_IPRI, 8'h20);
    repeat (3) @(posedge clk_i);
    cmp_sig({15'h0, irq}, 16'h1);
    cmp_sig({15'h0, irqh}, 16'h1);
    wr(`ADR_TT_CTRL, 8'h00);
    wr(`ADR_IEN, 8'h20);
    wr(`ADR_TT_CTRL, 8'h80);
    repeat (3) @(posedge clk_i);
    cmp_sig({15'h0, irq}, 16'h0);
    wr(`ADR_TT_CTRL, 8'h00);
    wr(`ADR_IEN, 8'hA0);
    wr(`ADR_TT_CNT_LO, 8'h34);
    wr(`ADR_TT_CTRL, 8'h0E);
    fall(0);
    rd(`ADR_TT_CTRL, 8'h4E);
    rd(`ADR_TT_CNT_LO, 8'hF0);
    cmp_sig({15'h0, irq}, 16'h1);
    v = 16'($urandom()) & 16'h7FFF;
    wr(`ADR_TT_CNT_LO, v[7:0]);
    wr(`ADR_TT_CNT_HI, v[15:8]);
    wr(`ADR_TT_CTRL, 8'h0F);
    fall(0);
    rd(`ADR_TT_RLD_LO, v[7:0]);
    rd(`ADR_TT_RLD_HI, v[15:8]);
    rd(`ADR_TT_CTRL, 8'h4F);
    repeat (3) fall(1);
    v = v + 16'h3;
    rd(`ADR_TT_CNT_LO, v[7:0]);
    rd(`ADR_TT_CNT_HI, v[15:8]);
    wr(`ADR_TT_CTRL, 8'h07);
    fall(0);
    rd(`ADR_TT_CTRL, 8'h07);
    wr(`ADR_TT_CTRL, 8'h02);
    fall(1);
    rd(`ADR_TT_CNT_LO, v[7:0]);
    wr(`ADR_TT_RLD_LO, 8'hFE);
    wr(`ADR_TT_RLD_HI, 8'hFF);
    wr(`ADR_TT_CNT_LO, 8'hFE);
    wr(`ADR_TT_CNT_HI, 8'hFF);
    wr(`ADR_SER_CTRL, 8'h80);
    wr(`ADR_TT_CTRL, 8'h34);
    n = 0;
    while (txt !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (txt !== 1'b1 && n < 50);
    cmp_sig(16'(n), 16'd4);
    cmp_sig({15'h0, rxt}, 16'h1);
    rd(`ADR_TT_CTRL, 8'h34);
    wr(`ADR_TT_CTRL, 8'h00);
    end_of_test();
  end
endmodule
